/* File: ccr_config_regs.sv */
// Configuration register bank of a two-cell boost charger with its two-wire serial slave.
// Assumes bus pins arrive asynchronously and an outer pad resolves sda from sda_oe.
`timescale 1ns/10ps
`default_nettype none
`include "ccr_defines.svh"

module ccr_config_regs #(
  parameter longint unsigned WD_BASE_CYCLES = 64'(`CCR_WD_BASE_S) * 64'(`CCR_CLK_HZ)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Two-wire serial bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Configuration fields
  output logic [2:0] charge_voltage_sel,
  output logic charge_enable_bit,
  output logic [2:0] sys_min_voltage_sel,
  output logic cell_overvoltage_hysteresis,
  output logic temp_profile_sel,
  output logic bal_start_sel,
  output logic mismatch_thr_falling,
  output logic mismatch_thr_rising,
  output logic [3:0] charge_current_sel,
  output logic switch_freq_sel,
  output logic [1:0] watchdog_period_sel,
  output logic [1:0] safety_timer_sel,
  output logic boost_run_ctrl,
  // Watchdog
  output logic watchdog_expiry_event
);

  logic [2:0] scl_s, sda_s;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  ccr_pkg::ccr_state_e state;
  logic [3:0] bit_cnt;
  logic is_read, wr_pulse, reg_reset, wd_kick;
  logic [1:0] index;
  ccr_pkg::ccr_byte_t shreg, tx, wr_data, rd_data;
  ccr_pkg::ccr_byte_t reg_volt, reg_bal, reg_tmr;
  logic [33:0] wd_cnt, wd_limit;

  // Two-flop synchronisers, preset to the idle-high bus so reset gives no false edge
  always_ff @(posedge clk)
  begin
    scl_s <= srst ? 3'h7 : {scl_s[1:0], scl};
    sda_s <= srst ? 3'h7 : {sda_s[1:0], sda_in};
  end

  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign bus_start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign bus_stop = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  assign rd_data = (index == `CCR_OFS_VOLT) ? reg_volt
                 : (index == `CCR_OFS_BAL) ? reg_bal
                 : (index == `CCR_OFS_TMR) ? reg_tmr : 8'h00;

  // Serial slave; the bus only ever pulls low, so sda_out stays at zero
  always_ff @(posedge clk)
  begin
    wr_pulse <= 1'b0;
    if (srst)
    begin
      state <= ccr_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      is_read <= 1'b0;
      index <= 2'h0;
      wr_data <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (bus_start)
    begin
      state <= ccr_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (bus_stop)
    begin
      state <= ccr_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state)
        ccr_pkg::ST_ADDR, ccr_pkg::ST_INDEX, ccr_pkg::ST_WDATA:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == 4'h8)
          begin
            bit_cnt <= 4'h0;
            if (state == ccr_pkg::ST_ADDR)
            begin
              if (shreg[7:1] == `CCR_BUS_ADDR)
              begin
                sda_oe <= 1'b1;
                is_read <= shreg[0];
                state <= ccr_pkg::ST_ADDR_ACK;
              end
              else
                state <= ccr_pkg::ST_IDLE;
            end
            else if (state == ccr_pkg::ST_INDEX)
            begin
              if (shreg < `CCR_NUM_REGS)
              begin
                sda_oe <= 1'b1;
                index <= shreg[1:0];
                state <= ccr_pkg::ST_INDEX_ACK;
              end
              else
                state <= ccr_pkg::ST_IDLE;
            end
            else
            begin
              sda_oe <= 1'b1;
              wr_pulse <= 1'b1;
              wr_data <= shreg;
              state <= ccr_pkg::ST_WDATA_ACK;
            end
          end
        end
        ccr_pkg::ST_ADDR_ACK:
          if (scl_fall)
          begin
            if (is_read)
            begin
              tx <= rd_data;
              sda_oe <= ~rd_data[7];
              state <= ccr_pkg::ST_RDATA;
            end
            else
            begin
              sda_oe <= 1'b0;
              state <= ccr_pkg::ST_INDEX;
            end
          end
        ccr_pkg::ST_RDATA:
          if (scl_fall)
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h7)
            begin
              sda_oe <= 1'b0;
              state <= ccr_pkg::ST_RDATA_ACK;
            end
            else
            begin
              tx <= {tx[6:0], 1'b0};
              sda_oe <= ~tx[6];
            end
          end
        // Single-byte only: after the data byte, further bytes are ignored until the next start
        ccr_pkg::ST_INDEX_ACK, ccr_pkg::ST_WDATA_ACK, ccr_pkg::ST_RDATA_ACK:
          if (scl_fall)
          begin
            sda_oe <= 1'b0;
            state <= (state == ccr_pkg::ST_INDEX_ACK) ? ccr_pkg::ST_WDATA : ccr_pkg::ST_IDLE;
          end
        default:
          state <= ccr_pkg::ST_IDLE;
      endcase
    end
  end

  // Register bank; a write in the expiry cycle overrides the restore of the register it writes
  assign reg_reset = wr_pulse && index == `CCR_OFS_TMR && wr_data[`CCR_REGRST_BIT];

  always_ff @(posedge clk)
  begin
    // Default of the reset bit is zero, so it clears itself here
    if (srst || reg_reset)
    begin
      reg_volt <= `CCR_DEF_VOLT;
      reg_bal <= `CCR_DEF_BAL;
      reg_tmr <= `CCR_DEF_TMR;
    end
    else
    begin
      if (watchdog_expiry_event)
      begin
        reg_volt <= (reg_volt & ~`CCR_WDM_VOLT) | (`CCR_DEF_VOLT & `CCR_WDM_VOLT);
        reg_bal <= (reg_bal & ~`CCR_WDM_BAL) | (`CCR_DEF_BAL & `CCR_WDM_BAL);
        reg_tmr <= (reg_tmr & ~`CCR_WDM_TMR) | (`CCR_DEF_TMR & `CCR_WDM_TMR);
      end
      if (wr_pulse)
        case (index)
          `CCR_OFS_VOLT: reg_volt <= wr_data;
          `CCR_OFS_BAL: reg_bal <= wr_data;
          `CCR_OFS_TMR: reg_tmr <= wr_data;
          default: ;
        endcase
    end
  end

  assign charge_voltage_sel = reg_volt[`CCR_VOLT_SEL_MSB:`CCR_VOLT_SEL_LSB];
  assign charge_enable_bit = reg_volt[`CCR_CHG_EN_BIT];
  assign sys_min_voltage_sel = reg_volt[`CCR_SYSMIN_MSB:`CCR_SYSMIN_LSB];
  assign cell_overvoltage_hysteresis = reg_volt[`CCR_HYS_BIT];
  assign temp_profile_sel = reg_bal[`CCR_TEMP_BIT];
  assign bal_start_sel = reg_bal[`CCR_BAL_START_BIT];
  assign mismatch_thr_falling = reg_bal[`CCR_THR_FALL_BIT];
  assign mismatch_thr_rising = reg_bal[`CCR_THR_RISE_BIT];
  assign charge_current_sel = reg_bal[`CCR_ICC_MSB:`CCR_ICC_LSB];
  assign switch_freq_sel = reg_tmr[`CCR_FSW_BIT];
  assign watchdog_period_sel = reg_tmr[`CCR_WDP_MSB:`CCR_WDP_LSB];
  assign safety_timer_sel = reg_tmr[`CCR_SAFE_MSB:`CCR_SAFE_LSB];
  assign boost_run_ctrl = reg_tmr[`CCR_BOOST_BIT];

  // Watchdog; a register reset also restarts it
  assign wd_kick = reg_reset
                   || (wr_pulse && index == `CCR_OFS_TMR && wr_data[`CCR_KICK_BIT]);

  // Periods double per code; code 00 holds the counter cleared, so its limit is unused
  assign wd_limit = 34'(WD_BASE_CYCLES) << (watchdog_period_sel - 2'h1);

  always_ff @(posedge clk)
  begin
    watchdog_expiry_event <= 1'b0;
    if (srst || wd_kick || watchdog_period_sel == 2'h0)
      wd_cnt <= 34'h0;
    else if (wd_cnt == wd_limit - 34'h1)
    begin
      wd_cnt <= 34'h0;
      watchdog_expiry_event <= 1'b1;
    end
    else
      wd_cnt <= wd_cnt + 34'h1;
  end

  por_defaults_a: assert property (@(posedge clk) srst |=> reg_volt == `CCR_DEF_VOLT
    && reg_bal == `CCR_DEF_BAL && reg_tmr == `CCR_DEF_TMR)
    else $error("defaults not loaded after reset");
  voltage_write_a: assert property (@(posedge clk) disable iff (srst)
    wr_pulse && index == `CCR_OFS_VOLT |=> charge_voltage_sel == $past(wr_data[7:5]))
    else $error("regulation voltage field not written");
  charge_enable_a: assert property (@(posedge clk) disable iff (srst)
    wr_pulse && index == `CCR_OFS_VOLT |=> charge_enable_bit == $past(wr_data[4]))
    else $error("charge enable not written");
  wd_kick_restart_a: assert property (@(posedge clk) disable iff (srst)
    wd_kick |=> wd_cnt == 34'h0 && !watchdog_expiry_event)
    else $error("watchdog not restarted by kick");
  reg_reset_a: assert property (@(posedge clk) disable iff (srst)
    wr_pulse && index == `CCR_OFS_TMR && wr_data[3] |=> reg_volt == `CCR_DEF_VOLT
    && reg_bal == `CCR_DEF_BAL && reg_tmr == `CCR_DEF_TMR && !reg_tmr[3])
    else $error("register reset did not restore defaults");
  boost_suspend_a: assert property (@(posedge clk) disable iff (srst)
    wr_pulse && index == `CCR_OFS_TMR && wr_data[3:0] == 4'h0 |=> !boost_run_ctrl)
    else $error("boost not suspended");
  bad_index_nack_a: assert property (@(posedge clk) disable iff (srst)
    state == ccr_pkg::ST_INDEX && scl_fall && bit_cnt == 4'h8 && shreg >= `CCR_NUM_REGS
    && !bus_start && !bus_stop |=> state == ccr_pkg::ST_IDLE && !sda_oe)
    else $error("undefined index not refused");
  addr_ack_a: assert property (@(posedge clk) disable iff (srst)
    state == ccr_pkg::ST_ADDR && scl_fall && bit_cnt == 4'h8 && shreg[7:1] == 7'h4B
    && !bus_start && !bus_stop |=> sda_oe ##0 state == ccr_pkg::ST_ADDR_ACK)
    else $error("own address not acknowledged");
  wd_restore_a: assert property (@(posedge clk) disable iff (srst)
    watchdog_expiry_event && !wr_pulse |=> charge_voltage_sel == 3'h1
    && reg_bal == `CCR_DEF_BAL && $stable(sys_min_voltage_sel)
    && $stable(watchdog_period_sel) && $stable(cell_overvoltage_hysteresis))
    else $error("watchdog restore wrong");

  write_seen_c: cover property (@(posedge clk) wr_pulse && index == `CCR_OFS_BAL);
  read_seen_c: cover property (@(posedge clk) state == ccr_pkg::ST_RDATA_ACK);
  expiry_seen_c: cover property (@(posedge clk) watchdog_expiry_event);
  reg_reset_c: cover property (@(posedge clk) wr_pulse && wr_data[3] && index == 2'h2);

endmodule : ccr_config_regs
`default_nettype wire

/* File: ccr_defines.svh */
// Constants for the charger configuration register bank.
// Assumes inclusion by bare name; definitions only.
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

// Serial bus address, 7 bits
`define CCR_BUS_ADDR 7'h4B

// Register offsets
`define CCR_OFS_VOLT 2'h0
`define CCR_OFS_BAL 2'h1
`define CCR_OFS_TMR 2'h2
`define CCR_NUM_REGS 8'h03

// Power-on and register-reset defaults
`define CCR_DEF_VOLT 8'h38
`define CCR_DEF_BAL 8'h8F
`define CCR_DEF_TMR 8'h95

// Fields that the watchdog expiry restores
`define CCR_WDM_VOLT 8'hF0
`define CCR_WDM_BAL 8'hFF
`define CCR_WDM_TMR 8'h87

// Field positions
`define CCR_VOLT_SEL_MSB 7
`define CCR_VOLT_SEL_LSB 5
`define CCR_CHG_EN_BIT 4
`define CCR_SYSMIN_MSB 3
`define CCR_SYSMIN_LSB 1
`define CCR_HYS_BIT 0
`define CCR_TEMP_BIT 7
`define CCR_BAL_START_BIT 6
`define CCR_THR_FALL_BIT 5
`define CCR_THR_RISE_BIT 4
`define CCR_ICC_MSB 3
`define CCR_ICC_LSB 0
`define CCR_FSW_BIT 7
`define CCR_KICK_BIT 6
`define CCR_WDP_MSB 5
`define CCR_WDP_LSB 4
`define CCR_REGRST_BIT 3
`define CCR_SAFE_MSB 2
`define CCR_SAFE_LSB 1
`define CCR_BOOST_BIT 0

// Watchdog timing: base period in seconds and clock rate
`define CCR_WD_BASE_S 40
`define CCR_CLK_HZ 50000000

`endif

/* File: ccr_host_model.sv */
// Bus host model for the charger configuration registers: single-byte writes and reads.
// Assumes the bench resolves open-drain sda with a pull-up and feeds it back as sda_w.
`timescale 1ns/10ps
`default_nettype none
`include "ccr_defines.svh"
module ccr_host_model (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda_w,
  output logic scl,
  output logic sda_m,
  // Read result
  output logic rd_done,
  output ccr_pkg::ccr_byte_t rd_byte
);
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  // Data moves only while scl is low, so the slave never sees a false start or stop
  task automatic put_bit(input logic b, output logic g);
    wait_n(2);
    sda_m = b;
    wait_n(3);
    scl = 1'b1;
    wait_n(4);
    g = sda_w;
    scl = 1'b0;
  endtask : put_bit

  // Also serves as repeated start
  task automatic start();
    wait_n(2);
    sda_m = 1'b1;
    wait_n(3);
    scl = 1'b1;
    wait_n(4);
    sda_m = 1'b0;
    wait_n(4);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    wait_n(2);
    sda_m = 1'b0;
    wait_n(3);
    scl = 1'b1;
    wait_n(4);
    sda_m = 1'b1;
    wait_n(4);
  endtask : stop

  task automatic xfer(input ccr_pkg::ccr_byte_t d, output ccr_pkg::ccr_byte_t q,
                      output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(d[i], g);
      q[i] = g;
    end
    put_bit(1'b1, ack);
  endtask : xfer

  task automatic wr(input logic [6:0] a, input ccr_pkg::ccr_byte_t idx, d, output logic ok);
    ccr_pkg::ccr_byte_t q;
    logic k0;
    logic k1;
    logic k2;
    start();
    xfer({a, 1'b0}, q, k0);
    xfer(idx, q, k1);
    xfer(d, q, k2);
    stop();
    ok = !(k0 | k1 | k2);
  endtask : wr

  // Read ends with a not-acknowledge from the host, as a single-byte read must
  task automatic rd(input ccr_pkg::ccr_byte_t idx);
    ccr_pkg::ccr_byte_t q;
    logic k;
    start();
    xfer({`CCR_BUS_ADDR, 1'b0}, q, k);
    xfer(idx, q, k);
    start();
    xfer({`CCR_BUS_ADDR, 1'b1}, q, k);
    xfer(8'hFF, q, k);
    stop();
    rd_byte = q;
    rd_done = 1'b1;
    wait_n(1);
    rd_done = 1'b0;
  endtask : rd
endmodule : ccr_host_model
`default_nettype wire

/* File: ccr_pkg.sv */
// Types for the charger configuration register bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ccr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_INDEX,
    ST_INDEX_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } ccr_state_e;

  typedef logic [7:0] ccr_byte_t;

endpackage : ccr_pkg
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the charger configuration registers through the bus host model.
// Assumes a shortened watchdog base so expiry is reached in a short run.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam longint unsigned WDC = 64'd6000;
  localparam logic [6:0] ADDR = 7'h4B;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic scl, sda_m, sda_out, sda_oe, rd_done, watchdog_expiry_event, ok;
  wire logic sda_w;
  ccr_pkg::ccr_byte_t rd_byte;
  logic [2:0] charge_voltage_sel, sys_min_voltage_sel;
  logic charge_enable_bit, cell_overvoltage_hysteresis, temp_profile_sel, bal_start_sel;
  logic mismatch_thr_falling, mismatch_thr_rising, switch_freq_sel, boost_run_ctrl;
  logic [3:0] charge_current_sel;
  logic [1:0] watchdog_period_sel, safety_timer_sel;
  ccr_pkg::ccr_byte_t exp_q[$];
  ccr_pkg::ccr_byte_t v[3];
  ccr_pkg::ccr_byte_t dflt[3] = '{8'h38, 8'h8F, 8'h95};
  int bad_count = 0;
  int n_compared = 0;
  int seed, r, cnt;

  // Pull-up on sda; either party may pull it low, the device through sda_out
  assign sda_w = sda_m & (sda_oe ? sda_out : 1'b1);
  always #10 clk = ~clk;

  ccr_config_regs #(.WD_BASE_CYCLES(WDC)) dut_u (
    .clk, .srst, .scl, .sda_in(sda_w), .sda_out, .sda_oe, .charge_voltage_sel,
    .charge_enable_bit, .sys_min_voltage_sel, .cell_overvoltage_hysteresis,
    .temp_profile_sel, .bal_start_sel, .mismatch_thr_falling, .mismatch_thr_rising,
    .charge_current_sel, .switch_freq_sel, .watchdog_period_sel, .safety_timer_sel,
    .boost_run_ctrl, .watchdog_expiry_event
  );
  ccr_host_model host_u (.clk, .sda_w, .scl, .sda_m, .rd_done, .rd_byte);

  task automatic chk(input ccr_pkg::ccr_byte_t g, e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Bits 6 and 3 of register two have no port
  function automatic ccr_pkg::ccr_byte_t view(input int i);
    if (i == 0)
      return {charge_voltage_sel, charge_enable_bit, sys_min_voltage_sel,
              cell_overvoltage_hysteresis};
    if (i == 1)
      return {temp_profile_sel, bal_start_sel, mismatch_thr_falling, mismatch_thr_rising,
              charge_current_sel};
    return {switch_freq_sel, 1'b0, watchdog_period_sel, 1'b0, safety_timer_sel, boost_run_ctrl};
  endfunction : view

  function automatic ccr_pkg::ccr_byte_t msk(input int i);
    return (i == 2) ? 8'hB7 : 8'hFF;
  endfunction : msk

  task automatic rdx(input int idx, input ccr_pkg::ccr_byte_t e);
    exp_q.push_back(e);
    host_u.rd(8'(idx));
  endtask : rdx

  task automatic wrx(input logic [6:0] a, input int idx, input ccr_pkg::ccr_byte_t d,
                     input logic e);
    host_u.wr(a, 8'(idx), d, ok);
    chk({7'h00, ok}, {7'h00, e});
  endtask : wrx

  always @(posedge clk)
    if (rd_done === 1'b1)
      chk(rd_byte, exp_q.pop_front());

  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial
  begin
    seed = 4740;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    for (int j = 0; j < 3; j++)
    begin
      chk(view(j), dflt[j] & msk(j));
      rdx(j, dflt[j]);
    end
    $display("test defaults done");
    // Every voltage code once, every period and safety timer code twice; kick set so the watchdog stays quiet
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      v[0] = {i[2:0], r[4:0]};
      v[1] = r[15:8];
      v[2] = {r[16], 1'b1, i[1:0], 1'b0, i[2:1], r[17]};
      for (int j = 2; j >= 0; j--)
        wrx(ADDR, j, v[j], 1'b1);
      for (int j = 0; j < 3; j++)
      begin
        rdx(j, v[j]);
        chk(view(j), v[j] & msk(j));
      end
    end
    $display("test fields done");
    wrx(7'h4A, 0, 8'h00, 1'b0);
    wrx(ADDR, 3, 8'h00, 1'b0);
    rdx(0, v[0]);
    $display("test refusal done");
    wrx(ADDR, 2, 8'h08, 1'b1);
    for (int j = 0; j < 3; j++)
    begin
      rdx(j, dflt[j]);
      chk(view(j), dflt[j] & msk(j));
    end
    $display("test register reset done");
    wrx(ADDR, 0, 8'hC5, 1'b1);
    wrx(ADDR, 1, 8'h00, 1'b1);
    wrx(ADDR, 2, 8'h50, 1'b1);
    cnt = 0;
    while (watchdog_expiry_event !== 1'b1 && cnt < WDC + 500)
    begin
      @(negedge clk);
      cnt++;
    end
    chk({7'h00, cnt > WDC - 100 && cnt < WDC + 10}, 8'h01);
    repeat (2) @(negedge clk);
    rdx(0, 8'h35);
    rdx(1, 8'h8F);
    rdx(2, 8'hD5);
    $display("test watchdog done");
    // A reset in mid-run must bring back the power-on values
    wrx(ADDR, 1, 8'h3C, 1'b1);
    @(negedge clk);
    srst = 1'b1;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    for (int j = 0; j < 3; j++)
    begin
      chk(view(j), dflt[j] & msk(j));
      rdx(j, dflt[j]);
    end
    $display("test mid-run reset done");
    chk(8'(exp_q.size()), 8'h00);
    summarize();
  end
endmodule : testbench
`default_nettype wire
